//--- logic/umci_top.sv
`timescale 1ns/10ps
module umci_top
  import umci_pkg::*;
#(
  parameter logic [7:0]   ID_COUNT   = 8'h04,          // Last implemented ident index
  parameter logic [127:0] VENDOR_STR = 128'h0000_0000_0065_726f_436c_6172_7475_654e,
                                                       // Arbitrary vendor text
  parameter logic [7:0]   VER_REV    = 8'h01,          // Arbitrary revision
  parameter logic [7:0]   VER_MODEL  = 8'h02,          // Arbitrary model
  parameter logic [7:0]   VER_FAMILY = 8'h03,          // Arbitrary family
  parameter logic [7:0]   VER_ARCH   = 8'h00,          // Arbitrary archrev
  parameter logic [63:0]  FEATURES   = 64'h0,          // Feature flag set
  parameter logic         SERIAL_SUP = 1'b1            // Serial number supported
) (
  input  wire logic               ref_clk,             // Core clock
  input  wire logic               nrst,                // Async reset, low
  input  wire logic               mask_wr_en,          // Software writes the mask
  input  wire logic [MASK_W-1:0]  mask_wr_data,        // Value written
  output      logic [MASK_W-1:0]  mask_rd_data,        // Current mask
  input  wire logic               fp_lo_done,          // Lower fp target completed
  input  wire logic               fp_hi_done,          // Upper fp target completed
  output      logic               pmon_enable,         // User monitors enabled
  input  wire logic               id_rd_req,           // Ident read request
  input  wire logic [7:0]         id_rd_index,         // Ident index
  input  wire logic [63:0]        serial_value,        // Serial number source
  input  wire logic               serial_disable,      // Serial number disabled
  output      logic               id_rd_valid,         // Ident data ready
  output      logic [63:0]        id_rd_data,          // Ident data
  output      logic               id_rd_fault,         // Reserved register fault
  input  wire logic               ls_req,              // Memory access request
  input  wire logic               ls_store,            // Store, else load
  input  wire umci_kind_t         ls_kind,             // Reference kind
  input  wire umci_size_t         ls_size,             // Access size code
  input  wire logic [ADDR_W-1:0]  ls_addr,             // Byte pointer
  input  wire logic [DATA_W-1:0]  ls_reg_data,         // Register value to store
  input  wire logic [DATA_W-1:0]  ls_mem_rdata,        // Memory bytes, lane 0 lowest
  output      logic               ls_done,             // Access result valid
  output      logic               ls_align_fault,      // Unaligned reference fault
  output      logic               ls_size_fault,       // Unknown size code
  output      logic [ADDR_W-1:0]  ls_mem_addr,         // Address to memory
  output      logic [LANES-1:0]   ls_byte_en,          // Memory lanes used
  output      logic [DATA_W-1:0]  ls_mem_wdata,        // Store bytes in memory order
  output      logic [DATA_W-1:0]  ls_load_data         // Load value, right-justified
);

  // Bytes moved by a size code, zero when unknown
  function automatic logic [4:0] size_bytes(input umci_size_t sz);
    case (sz)
      UMCI_SZ1:  size_bytes = 5'h01;
      UMCI_SZ2:  size_bytes = 5'h02;
      UMCI_SZ4:  size_bytes = 5'h04;
      UMCI_SZ8:  size_bytes = 5'h08;
      UMCI_SZ10: size_bytes = 5'h0a;
      UMCI_SZ16: size_bytes = 5'h10;
      default:   size_bytes = 5'h00;
    endcase
  endfunction

  // Keep the low n bytes, reversing them when swap is set
  function automatic logic [DATA_W-1:0] lane_order(input logic [DATA_W-1:0] d,
                                                   input logic [4:0]        n,
                                                   input logic              swap);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int k = 0; k < LANES; k++) begin
      if (5'(k) < n) begin
        if (swap) begin
          r[8*k +: 8] = d[8*(int'(n) - 1 - k) +: 8];
        end else begin
          r[8*k +: 8] = d[8*k +: 8];
        end
      end
    end
    lane_order = r;
  endfunction

  logic [1:0]         rst_sync_reg;                    // Reset release chain
  logic               rst_n;                           // Synchronised reset
  logic [MASK_W-1:0]  mask_reg;                        // Control mask
  logic [MASK_W-1:0]  mask_next;                       // Mask next value
  logic [4:0]         nbytes;                          // Size of current access
  logic [4:0]         align_n;                         // Natural alignment unit
  logic               misaligned;                      // Address off its unit
  logic               swap_bytes;                      // Big-endian steering applies
  logic [63:0]        id_value;                        // Selected ident word
  logic [63:0]        version_word;                    // Version register value

  // Reset released through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Mask next value: software write, then sticky hardware sets win
  always_comb begin
    mask_next = mask_reg;
    if (mask_wr_en) begin
      mask_next = mask_wr_data & MASK_WR_KEEP;
    end
    if (fp_lo_done) begin
      mask_next[MASK_FPLO_BIT] = 1'b1;
    end
    if (fp_hi_done) begin
      mask_next[MASK_FPHI_BIT] = 1'b1;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign mask_rd_data = mask_reg;
  assign pmon_enable  = mask_reg[MASK_PMON_BIT];

  // Version word fields
  always_comb begin
    version_word                       = '0;
    version_word[VER_NUM_LSB   +: 8]   = ID_COUNT;
    version_word[VER_REV_LSB   +: 8]   = VER_REV;
    version_word[VER_MODEL_LSB +: 8]   = VER_MODEL;
    version_word[VER_FAM_LSB   +: 8]   = VER_FAMILY;
    version_word[VER_ARCH_LSB  +: 8]   = VER_ARCH;
  end

  // Ident word select; variable region reads zero
  always_comb begin
    if (id_rd_index == ID_VENDOR_LO) begin
      id_value = VENDOR_STR[63:0];
    end else if (id_rd_index == ID_VENDOR_HI) begin
      id_value = VENDOR_STR[127:64];
    end else if (id_rd_index == ID_SERIAL) begin
      id_value = (SERIAL_SUP && !serial_disable) ? serial_value : 64'h0;
    end else if (id_rd_index == ID_VERSION) begin
      id_value = version_word;
    end else if (id_rd_index == ID_FEATURES) begin
      id_value = FEATURES;
    end else begin
      id_value = 64'h0;
    end
  end

  // Ident read answer one cycle later; no write path exists
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_rd_valid <= 1'b0;
      id_rd_fault <= 1'b0;
      id_rd_data  <= 64'h0;
    end else begin
      id_rd_valid <= id_rd_req;
      id_rd_fault <= id_rd_req && (id_rd_index > ID_COUNT);
      if (id_rd_req) begin
        id_rd_data <= (id_rd_index > ID_COUNT) ? 64'h0 : id_value;
      end
    end
  end

  // Access decode: size, alignment and byte steering
  always_comb begin
    nbytes     = size_bytes(ls_size);
    align_n    = (ls_size == UMCI_SZ10) ? 5'h10 : nbytes;
    misaligned = (nbytes != 5'h00) && ((ls_addr[3:0] & (align_n[3:0] - 4'h1)) != 4'h0);
    swap_bytes = mask_reg[MASK_BE_BIT]
                 && (ls_kind == UMCI_NATIVE)
                 && (nbytes > 5'h01);
  end

  // Access result registered one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_done        <= 1'b0;
      ls_align_fault <= 1'b0;
      ls_size_fault  <= 1'b0;
      ls_mem_addr    <= '0;
      ls_byte_en     <= '0;
      ls_mem_wdata   <= '0;
      ls_load_data   <= '0;
    end else begin
      ls_done        <= ls_req;
      ls_size_fault  <= ls_req && (nbytes == 5'h00);
      ls_align_fault <= ls_req && misaligned && (ls_kind != UMCI_FETCH)
                        && mask_reg[MASK_ALIGN_BIT];
      if (ls_req) begin
        ls_mem_addr  <= ls_addr;
        ls_byte_en   <= LANES'((17'h1 << nbytes) - 17'h1);
        ls_mem_wdata <= ls_store ? lane_order(ls_reg_data, nbytes, swap_bytes) : '0;
        ls_load_data <= ls_store ? '0
                        : lane_order(ls_mem_rdata, nbytes, swap_bytes);
      end
    end
  end

  // Checks
  sequence s_fp_lo_event;
    fp_lo_done;
  endsequence

  sequence s_flag_low_set;
    ##1 mask_reg[MASK_FPLO_BIT];
  endsequence

  property p_fp_lo_set;
    @(posedge ref_clk) disable iff (!rst_n)
    s_fp_lo_event |-> s_flag_low_set;
  endproperty
  a_fp_lo_set: assert property (p_fp_lo_set) else $error("lower fp flag not set");

  property p_fp_hi_set;
    @(posedge ref_clk) disable iff (!rst_n)
    fp_hi_done |=> mask_reg[MASK_FPHI_BIT];
  endproperty
  a_fp_hi_set: assert property (p_fp_hi_set) else $error("upper fp flag not set");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
    (mask_reg[MASK_FPLO_BIT] && !mask_wr_en) |=> mask_reg[MASK_FPLO_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("dirty flag dropped");

  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    mask_rd_data[MASK_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_pmon;
    @(posedge ref_clk) disable iff (!rst_n)
    mask_wr_en |=> (pmon_enable == $past(mask_wr_data[MASK_PMON_BIT]));
  endproperty
  a_pmon: assert property (p_pmon) else $error("monitor enable wrong");

  property p_id_fault;
    @(posedge ref_clk) disable iff (!rst_n)
    id_rd_req |=> (id_rd_valid && (id_rd_fault == ($past(id_rd_index) > ID_COUNT)));
  endproperty
  a_id_fault: assert property (p_id_fault) else $error("ident fault wrong");

  property p_align;
    @(posedge ref_clk) disable iff (!rst_n)
    (ls_req && mask_reg[MASK_ALIGN_BIT] && ls_kind != UMCI_FETCH && ls_addr[0]
     && ls_size != UMCI_SZ1 && nbytes != 5'h00) |=> ls_align_fault;
  endproperty
  a_align: assert property (p_align) else $error("unaligned not faulted");

  property p_legacy_le;
    @(posedge ref_clk) disable iff (!rst_n)
    (ls_req && !ls_store && ls_kind == UMCI_LEGACY && ls_size == UMCI_SZ2)
      |=> (ls_load_data[15:0] == $past(ls_mem_rdata[15:0]));
  endproperty
  a_legacy_le: assert property (p_legacy_le) else $error("legacy not little");

  property p_be_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (ls_req && !ls_store && ls_kind == UMCI_NATIVE && ls_size == UMCI_SZ2
     && mask_reg[MASK_BE_BIT])
      |=> (ls_load_data[15:0] == {$past(ls_mem_rdata[7:0]), $past(ls_mem_rdata[15:8])}
           && ls_load_data[DATA_W-1:16] == '0);
  endproperty
  a_be_load: assert property (p_be_load) else $error("big-endian load wrong");

  // Upper dirty flag is sticky as well
  property p_fp_hi_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
    (mask_reg[MASK_FPHI_BIT] && !mask_wr_en) |=> mask_reg[MASK_FPHI_BIT];
  endproperty
  a_fp_hi_sticky: assert property (p_fp_hi_sticky) else $error("upper flag dropped");

  // A plain software write lands as written, reserved bit dropped
  sequence s_plain_write;
    mask_wr_en && !fp_lo_done && !fp_hi_done;
  endsequence

  property p_mask_write;
    @(posedge ref_clk) disable iff (!rst_n)
    s_plain_write |=> (mask_rd_data == ($past(mask_wr_data) & MASK_WR_KEEP));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // Without a write or an fp event the mask never moves
  property p_mask_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (!mask_wr_en && !fp_lo_done && !fp_hi_done) |=> $stable(mask_rd_data);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed alone");

  // Ident answer pulses only after a request
  property p_id_idle;
    @(posedge ref_clk) disable iff (!rst_n)
    !id_rd_req |=> (!id_rd_valid && !id_rd_fault);
  endproperty
  a_id_idle: assert property (p_id_idle) else $error("ident answer unasked");

  // Serial word follows its source unless withheld
  sequence s_serial_read;
    id_rd_req && (id_rd_index == ID_SERIAL) && (ID_SERIAL <= ID_COUNT);
  endsequence

  property p_serial;
    @(posedge ref_clk) disable iff (!rst_n)
    s_serial_read |=> (id_rd_data == ((SERIAL_SUP && !$past(serial_disable))
                                      ? $past(serial_value) : 64'h0));
  endproperty
  a_serial: assert property (p_serial) else $error("serial word wrong");

  // Access answer pulses only after a request
  property p_ls_idle;
    @(posedge ref_clk) disable iff (!rst_n)
    !ls_req |=> (!ls_done && !ls_align_fault && !ls_size_fault);
  endproperty
  a_ls_idle: assert property (p_ls_idle) else $error("access answer unasked");

  property p_ls_done;
    @(posedge ref_clk) disable iff (!rst_n)
    ls_req |=> (ls_done && ls_mem_addr == $past(ls_addr));
  endproperty
  a_ls_done: assert property (p_ls_done) else $error("access not answered");

  property p_size_fault;
    @(posedge ref_clk) disable iff (!rst_n)
    ls_req |=> (ls_size_fault == ($past(ls_size) > UMCI_SZ16));
  endproperty
  a_size_fault: assert property (p_size_fault) else $error("size fault wrong");

  // No fault for fetch, or while the check bit is clear
  property p_no_align;
    @(posedge ref_clk) disable iff (!rst_n)
    (ls_req && (!mask_reg[MASK_ALIGN_BIT] || ls_kind == UMCI_FETCH)) |=> !ls_align_fault;
  endproperty
  a_no_align: assert property (p_no_align) else $error("spurious align fault");

  // Byte loads ignore byte order and sit right-justified
  property p_byte_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (ls_req && !ls_store && ls_size == UMCI_SZ1)
      |=> (ls_load_data == {120'h0, $past(ls_mem_rdata[7:0])});
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load wrong");

  // Big-endian half-word stores swap their two bytes
  sequence s_be_native_half;
    ls_req && ls_kind == UMCI_NATIVE && ls_size == UMCI_SZ2 && mask_reg[MASK_BE_BIT];
  endsequence

  property p_be_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_be_native_half ##0 ls_store)
      |=> (ls_mem_wdata[15:0] == {$past(ls_reg_data[7:0]), $past(ls_reg_data[15:8])});
  endproperty
  a_be_store: assert property (p_be_store) else $error("big-endian store wrong");

endmodule

//--- logic/umci_pkg.sv
// Behaviour
// - Mask bit 1 picks native data byte order
// - Legacy data references always little-endian
// - Mask bit 2 enables user performance monitors
// - Mask bit 3 faults every unaligned reference except fetch
// - Lower floating-point writes set mask bit 4
// - Upper floating-point writes set mask bit 5
// - Dirty flags cleared only by software write
// - Ident file: fixed 0-4, variable above
// - Index above count raises reserved fault
// - Ident registers readable, never writable
// - Registers 0-1 hold zero-padded ASCII vendor
// - Register 2 serial number or zero
// - Register 3 holds 40-bit version fields
// - Register 4 feature flags, zero means baseline
// - Big-endian maps low address to high byte
// - Byte, fetch, legacy, stack ignore byte order
// - Fetch always little-endian units
// - Loads right-justified in target register
// - Access sizes 1,2,4,8,10,16 bytes
// - Addresses are 64-bit byte pointers
package umci_pkg;

  // Control mask layout
  localparam int          MASK_W         = 6;
  localparam int          MASK_RSVD_BIT  = 0;
  localparam int          MASK_BE_BIT    = 1;
  localparam int          MASK_PMON_BIT  = 2;
  localparam int          MASK_ALIGN_BIT = 3;
  localparam int          MASK_FPLO_BIT  = 4;
  localparam int          MASK_FPHI_BIT  = 5;
  localparam logic [5:0]  MASK_RESET     = 6'h00;
  localparam logic [5:0]  MASK_WR_KEEP   = 6'h3e;

  // Identification file indices
  localparam logic [7:0]  ID_VENDOR_LO   = 8'h00;
  localparam logic [7:0]  ID_VENDOR_HI   = 8'h01;
  localparam logic [7:0]  ID_SERIAL      = 8'h02;
  localparam logic [7:0]  ID_VERSION     = 8'h03;
  localparam logic [7:0]  ID_FEATURES    = 8'h04;
  localparam logic [7:0]  ID_FIXED_LAST  = 8'h04;

  // Version register field positions
  localparam int          VER_NUM_LSB    = 0;
  localparam int          VER_REV_LSB    = 8;
  localparam int          VER_MODEL_LSB  = 16;
  localparam int          VER_FAM_LSB    = 24;
  localparam int          VER_ARCH_LSB   = 32;

  // Data path widths
  localparam int          ADDR_W         = 64;
  localparam int          LANES          = 16;
  localparam int          DATA_W         = 128;

  // Access size codes
  typedef enum logic [2:0] {
    UMCI_SZ1, UMCI_SZ2, UMCI_SZ4, UMCI_SZ8, UMCI_SZ10, UMCI_SZ16
  } umci_size_t;

  // Kind of memory reference
  typedef enum logic [1:0] {
    UMCI_NATIVE, UMCI_LEGACY, UMCI_STACK, UMCI_FETCH
  } umci_kind_t;

endpackage

//--- test/umci_mem_model.sv
`timescale 1ns/10ps
// Memory side of the load/store path: a fixed byte ramp on every lane
module umci_mem_model
  import umci_pkg::*;
(
  output logic [DATA_W-1:0] mem_rdata  // Lane i holds 8'ha0 plus i
);
  // A different byte in each lane shows any swap, shift or lost lane
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      mem_rdata[i*8 +: 8] = 8'ha0 + 8'(i);
    end
  end
endmodule

//--- test/test_umci_top.sv
`timescale 1ns/10ps
module test_umci_top
  import umci_pkg::*;
();
  localparam logic [127:0] VEND = 128'h78616c62726f5a;  // Arbitrary vendor text
  localparam logic [63:0]  SER  = 64'h0123456789abcdef; // Arbitrary serial
  logic             ref_clk, nrst, mask_wr_en, fp_lo_done, fp_hi_done;
  logic             id_rd_req, serial_disable, ls_req, ls_store;
  logic             pmon_enable, id_rd_valid, id_rd_fault, ls_done;
  logic             ls_align_fault, ls_size_fault, seen_ok, seen_flt;
  logic [5:0]       mask_wr_data, mask_rd_data;
  logic [7:0]       id_rd_index;
  logic [63:0]      serial_value, id_rd_data, ls_addr, ls_mem_addr;
  logic [15:0]      ls_byte_en;
  logic [127:0]     ls_reg_data, ls_mem_rdata, ls_mem_wdata, ls_load_data, exp;
  umci_kind_t       ls_kind;
  umci_size_t       ls_size;
  int               n_errors, checks_done;

  umci_top #(.ID_COUNT(8'h05), .VENDOR_STR(VEND), .VER_REV(8'h11), .VER_MODEL(8'h22),
    .VER_FAMILY(8'h33), .VER_ARCH(8'h44))
  i_umci_top (.ref_clk, .nrst, .mask_wr_en, .mask_wr_data, .mask_rd_data, .fp_lo_done,
    .fp_hi_done, .pmon_enable, .id_rd_req, .id_rd_index, .serial_value, .serial_disable,
    .id_rd_valid, .id_rd_data, .id_rd_fault, .ls_req, .ls_store, .ls_kind, .ls_size,
    .ls_addr, .ls_reg_data, .ls_mem_rdata, .ls_done, .ls_align_fault, .ls_size_fault,
    .ls_mem_addr, .ls_byte_en, .ls_mem_wdata, .ls_load_data);
  umci_mem_model i_umci_mem_model (.mem_rdata(ls_mem_rdata));

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare one value and count it
  task automatic check(string what, logic [127:0] seen, logic [127:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Move just past the next rising edge
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Software mask write, one-cycle strobe
  task automatic wr_mask(logic [5:0] v);
    mask_wr_en   = 1'b1;
    mask_wr_data = v;
    step();
    mask_wr_en = 1'b0;
    step();
  endtask

  // One ident read; valid and fault are caught in their single cycle
  task automatic id_read(logic [7:0] idx);
    id_rd_req   = 1'b1;
    id_rd_index = idx;
    step();
    id_rd_req = 1'b0;
    seen_ok   = id_rd_valid;
    seen_flt  = id_rd_fault;
    step();
    check("id valid", 128'(seen_ok), 128'h1);
  endtask

  // One memory access; done and align fault captured when they pulse
  task automatic ls_op(umci_kind_t k, umci_size_t s, logic [63:0] a, logic st,
                       logic [127:0] d);
    ls_req      = 1'b1;
    ls_kind     = k;
    ls_size     = s;
    ls_addr     = a;
    ls_store    = st;
    ls_reg_data = d;
    step();
    ls_req   = 1'b0;
    seen_ok  = ls_done;
    seen_flt = ls_align_fault;
    step();
    check("ls done", 128'(seen_ok), 128'h1);
  endtask

  // Mask reset, reserved bit and monitor enable
  task automatic t_mask();
    check("mask reset", 128'(mask_rd_data), 128'h0);
    wr_mask(6'h3f);
    check("mask rsvd", 128'(mask_rd_data), 128'h3e);
    check("pmon on", 128'(pmon_enable), 128'h1);
    wr_mask(6'h00);
    check("pmon off", 128'(pmon_enable), 128'h0);
  endtask

  // Sticky floating-point dirty flags
  task automatic t_dirty();
    fp_lo_done = 1'b1;
    step();
    fp_lo_done = 1'b0;
    step();
    check("fp low", 128'(mask_rd_data), 128'h10);
    fp_hi_done = 1'b1;
    step();
    fp_hi_done = 1'b0;
    repeat (4) step();
    check("fp sticky", 128'(mask_rd_data), 128'h30);
    wr_mask(6'h04);
    check("fp cleared", 128'(mask_rd_data), 128'h04);
    // Clearing write and upper event on one edge: the set wins
    fp_hi_done = 1'b1;
    wr_mask(6'h00);
    fp_hi_done = 1'b0;
    check("set wins", 128'(mask_rd_data), 128'h20);
  endtask

  // Ident file: fixed entries, variable entry, out-of-range index
  task automatic t_ident();
    logic [63:0] want [7];
    want = '{VEND[63:0], VEND[127:64], SER, 64'h44_3322_1105, 64'h0, 64'h0, 64'h0};
    for (int i = 0; i < 7; i++) begin
      id_read(8'(i));
      check("id data", 128'(id_rd_data), 128'(want[i]));
      check("id fault", 128'(seen_flt), (i == 6) ? 128'h1 : 128'h0);
    end
    serial_disable = 1'b1;
    id_read(ID_SERIAL);
    check("serial off", 128'(id_rd_data), 128'h0);
  endtask

  // Byte order by kind and size, stores included
  task automatic t_order();
    wr_mask(6'h02);
    ls_op(UMCI_NATIVE, UMCI_SZ4, 64'h0, 1'b0, 128'h0);
    check("be load", ls_load_data, 128'ha0a1a2a3);
    ls_op(UMCI_NATIVE, UMCI_SZ2, 64'h0, 1'b0, 128'h0);
    check("be half", ls_load_data, 128'ha0a1);
    ls_op(UMCI_LEGACY, UMCI_SZ4, 64'h0, 1'b0, 128'h0);
    check("legacy", ls_load_data, 128'ha3a2a1a0);
    ls_op(UMCI_STACK, UMCI_SZ4, 64'h0, 1'b0, 128'h0);
    check("stack", ls_load_data, 128'ha3a2a1a0);
    ls_op(UMCI_FETCH, UMCI_SZ4, 64'h0, 1'b0, 128'h0);
    check("fetch", ls_load_data, 128'ha3a2a1a0);
    ls_op(UMCI_NATIVE, UMCI_SZ1, 64'h0, 1'b0, 128'h0);
    check("byte load", ls_load_data, 128'ha0);
    ls_op(UMCI_NATIVE, UMCI_SZ2, 64'h0, 1'b1, 128'h1234);
    check("be store", ls_mem_wdata, 128'h3412);
    wr_mask(6'h00);
    ls_op(UMCI_NATIVE, UMCI_SZ2, 64'h0, 1'b1, 128'h1234);
    check("le store", ls_mem_wdata, 128'h1234);
  endtask

  // Every access size: lanes, address and right-justified data
  task automatic t_sizes();
    int n [6];
    n = '{1, 2, 4, 8, 10, 16};
    for (int s = 0; s < 6; s++) begin
      ls_op(umci_kind_t'(2'(s)), UMCI_SZ1, 64'h0, 1'b0, 128'h0);
      ls_op(UMCI_NATIVE, umci_size_t'(s), 64'hfedc_0000_0000_1000, 1'b0, 128'h0);
      exp = '0;
      for (int j = 0; j < n[s]; j++) begin
        exp[j*8 +: 8] = 8'ha0 + 8'(j);
      end
      check("byte en", 128'(ls_byte_en), 128'((17'h1 << n[s]) - 17'h1));
      check("addr", 128'(ls_mem_addr), 128'hfedc_0000_0000_1000);
      check("size load", ls_load_data, exp);
    end
  endtask

  // Alignment faults and an unknown size code
  task automatic t_align();
    wr_mask(6'h08);
    ls_op(UMCI_NATIVE, UMCI_SZ4, 64'h2, 1'b0, 128'h0);
    check("align n4", 128'(seen_flt), 128'h1);
    ls_op(UMCI_LEGACY, UMCI_SZ2, 64'h1, 1'b0, 128'h0);
    check("align l2", 128'(seen_flt), 128'h1);
    ls_op(UMCI_NATIVE, UMCI_SZ10, 64'h10, 1'b0, 128'h0);
    check("align 10", 128'(seen_flt), 128'h0);
    ls_op(UMCI_FETCH, UMCI_SZ16, 64'h8, 1'b0, 128'h0);
    check("align ftch", 128'(seen_flt), 128'h0);
    wr_mask(6'h00);
    ls_op(UMCI_NATIVE, UMCI_SZ4, 64'h2, 1'b0, 128'h0);
    check("align off", 128'(seen_flt), 128'h0);
    ls_req  = 1'b1;
    ls_size = umci_size_t'(3'h6);
    step();
    ls_req = 1'b0;
    check("size flt", 128'(ls_size_fault), 128'h1);
    step();
  endtask

  // Main sequence
  initial begin
    {nrst, mask_wr_en, fp_lo_done, fp_hi_done, id_rd_req, serial_disable} = '0;
    {ls_req, ls_store, mask_wr_data, id_rd_index, ls_addr, ls_reg_data} = '0;
    {n_errors, checks_done} = '0;
    serial_value = SER;
    ls_kind      = UMCI_NATIVE;
    ls_size      = UMCI_SZ1;
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (3) step();
    t_mask();
    t_dirty();
    t_ident();
    t_order();
    t_sizes();
    t_align();
    print_verdict();
  end
endmodule
